// *** rmc_chk.sv ***
`timescale 1ns/1ps
`include "rmc_consts.vh"
// Port checks of the relay controller; one clock domain, so one shared clocking.
module rmc_chk #(
    parameter NCH = 25
) (
    input logic          clk_sys_in,
    input logic          nrst_in,
    input logic          ce_in,
    input logic [3:0]    function_sel_in,
    input logic          interval_wr_in,
    input logic [10:0]   interval_in,
    input logic          count_query_in,
    input logic [4:0]    query_first_in,
    input logic [4:0]    query_last_in,
    input logic [NCH:1]  relay_out,
    input logic [10:0]   interval_out,
    input logic          interval_err_out,
    input logic          count_valid_out,
    input logic [4:0]    count_chan_out,
    input logic          query_busy_out,
    input logic          nv_wr_out,
    input logic [4:0]    nv_addr_out,
    input logic          save_busy_out
);
    // Accepted query and refused interval write, seen from the host side.
    wire q_ok = ce_in && count_query_in && !query_busy_out && query_first_in != 5'h00 &&
        query_first_in <= query_last_in && query_last_in <= 5'h19;
    wire wr_bad = ce_in && interval_wr_in &&
        (interval_in < `RMC_INT_MIN_MIN || interval_in > `RMC_INT_MAX_MIN);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // Two measurement relays may be closed together only as a four-wire pair.
    property p_one; $countones(relay_out[22:1]) < 2 || ($countones(relay_out[22:1]) == 2 &&
        relay_out[20:11] == relay_out[10:1]); endproperty
    a_one: assert property (p_one) else $error("extra channel closed");
    property p_pole2; ce_in && function_sel_in == `RMC_FN_DCV |=> !relay_out[23]; endproperty
    a_pole2: assert property (p_pole2) else $error("pole relay closed");
    property p_pole4; ce_in && function_sel_in == `RMC_FN_RES4 |=> relay_out[23]; endproperty
    a_pole4: assert property (p_pole4) else $error("pole relay open");
    property p_amps; ce_in && function_sel_in == `RMC_FN_DCI |=>
        relay_out[25:23] == 3'h0 && relay_out[20:1] == 20'h00000; endproperty
    a_amps: assert property (p_amps) else $error("amps routing");
    property p_bad; wr_bad |=> interval_err_out && $stable(interval_out); endproperty
    a_bad: assert property (p_bad) else $error("bad interval taken");
    property p_query; q_ok |=> query_busy_out ##1
        count_valid_out && count_chan_out == $past(query_first_in, 2); endproperty
    a_query: assert property (p_query) else $error("query timing");
    property p_save; ce_in && count_query_in && !save_busy_out |->
        ##[1:2] nv_wr_out && nv_addr_out == 5'h01; endproperty
    a_save: assert property (p_save) else $error("save not started");
    property p_nv; nv_wr_out |-> save_busy_out; endproperty
    a_nv: assert property (p_nv) else $error("stray store write");
    // Main scenarios reached.
    c_query: cover property (count_valid_out);
    c_save: cover property (nv_wr_out && nv_addr_out == 5'h19);
    c_bad: cover property (interval_err_out);
endmodule
bind rmc_relay_ctrl rmc_chk #(.NCH(NCH)) rmc_chk_i (
    .clk_sys_in       (clk_sys_in),
    .nrst_in          (nrst_in),
    .ce_in            (ce_in),
    .function_sel_in  (function_sel_in),
    .interval_wr_in   (interval_wr_in),
    .interval_in      (interval_in),
    .count_query_in   (count_query_in),
    .query_first_in   (query_first_in),
    .query_last_in    (query_last_in),
    .relay_out        (relay_out),
    .interval_out     (interval_out),
    .interval_err_out (interval_err_out),
    .count_valid_out  (count_valid_out),
    .count_chan_out   (count_chan_out),
    .query_busy_out   (query_busy_out),
    .nv_wr_out        (nv_wr_out),
    .nv_addr_out      (nv_addr_out),
    .save_busy_out    (save_busy_out)
);

// *** rmc_consts.vh ***
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH
`define RMC_NUM_MEAS         22
`define RMC_NUM_SIGNAL       20
`define RMC_PAIR_OFFSET      10
`define RMC_CH_POLE_SEL      23
`define RMC_CH_BP_SENSE      24
`define RMC_CH_BP_INPUT      25
`define RMC_CH_AMPS_A        21
`define RMC_CH_AMPS_B        22
`define RMC_INT_DEFAULT_MIN  11'h00F
`define RMC_INT_MIN_MIN      11'h00A
`define RMC_INT_MAX_MIN      11'h5A0
`define RMC_CNT_W            32
`define RMC_FN_DCV           4'h0
`define RMC_FN_ACV           4'h1
`define RMC_FN_DCI           4'h2
`define RMC_FN_ACI           4'h3
`define RMC_FN_RES2          4'h4
`define RMC_FN_RES4          4'h5
`define RMC_FN_CONTINUITY_TEST          4'h6
`define RMC_FN_FREQ          4'h7
`define RMC_FN_PERIOD        4'h8
`define RMC_FN_TEMP2         4'h9
`define RMC_FN_TEMP_RTD4     4'hA
`define RMC_FN_RATIO         4'hB
`define RMC_FN_CHAVG         4'hC
`endif

// *** rmc_nv_model.sv ***
`timescale 1ns/1ps
// Card store model; a slow store is ready only every other cycle.
module rmc_nv_model (
    input  logic        clk_sys_in,
    input  logic        nrst_in,
    input  logic        slow_in,
    input  logic        nv_wr_in,
    input  logic [4:0]  nv_addr_in,
    input  logic [31:0] nv_data_in,
    output logic        nv_ready_out
);
    logic [31:0] mem [1:25];
    // Ready moves on the falling edge so the controller samples it settled.
    always @(negedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nv_ready_out <= 1'b0;
        end else begin
            nv_ready_out <= slow_in ? !nv_ready_out : 1'b1;
        end
    end
    // A word lands where request and ready meet.
    always @(posedge clk_sys_in) begin
        if (nv_wr_in && nv_ready_out) begin
            mem[nv_addr_in] <= nv_data_in;
        end
    end
endmodule

// *** rmc_relay_ctrl.v ***
`timescale 1ns/1ps
`include "rmc_consts.vh"
// Function
// - Every open-to-closed relay transition increments its volatile count, any cause.
// - Only open-to-closed transitions count; repeated closes do nothing.
// - Counts copy to nonvolatile store on interval expiry or query; default 15 min.
// - Save interval is whole minutes 10 to 1440; other values are refused.
// - A count query returns the count of each listed channel.
// - At most one measurement channel or pair closed; closing opens others.
// - Relays 23, 24, 25 follow the function; user requests leave them.
// - Current functions offer channels 21-22; four-wire ones offer 1-10; others offer channels 1-20.
// - Four-wire: closing primary N (1-10) also closes sense channel N+10.
// - Four-wire ops are four-wire ohms, RTD, ratio, averaging; rest two-wire.
// - Two-wire non-current closes relay 25; four-wire closes 24 and 25.
// - Two-wire opens pole-select relay 23.
// - Four-wire closes pole-select relay 23.
// - Current channels 21, 22 go straight to the backplane.
// - In multiple-channel mode, relays 24 and 25 may be set independently, except under current functions, which hold both open.
module rmc_relay_ctrl #(
    parameter NCH = 25,
    parameter CW  = `RMC_CNT_W
) (
    input  wire          clk_sys_in,
    input  wire          nrst_in,
    input  wire          ce_in,
    input  wire [3:0]    function_sel_in,
    input  wire          close_req_in,
    input  wire          open_req_in,
    input  wire [4:0]    chan_in,
    input  wire          multi_mode_in,
    input  wire          bp_sense_set_in,
    input  wire          bp_input_set_in,
    input  wire          interval_wr_in,
    input  wire [10:0]   interval_in,
    input  wire          minute_tick_in,
    input  wire          count_query_in,
    input  wire [4:0]    query_first_in,
    input  wire [4:0]    query_last_in,
    input  wire          nv_ready_in,
    output reg  [NCH:1]  relay_out,
    output reg  [10:0]   interval_out,
    output reg           interval_err_out,
    output reg           count_valid_out,
    output reg  [4:0]    count_chan_out,
    output reg  [CW-1:0] count_data_out,
    output reg           query_busy_out,
    output reg           nv_wr_out,
    output reg  [4:0]    nv_addr_out,
    output reg  [CW-1:0] nv_data_out,
    output reg           save_busy_out
);
    // Volatile closure counts, one word per relay.
    reg [CW-1:0] count_mem [1:NCH];
    reg [NCH:1]  nxt_relay;
    reg [4:0]    qptr_ff;
    reg [4:0]    qlast_ff;
    reg [4:0]    sptr_ff;
    reg          save_pend_ff;
    wire         timer_expire;
    wire         save_done;
    integer      i;

    // Function class decodes, reused in several places.
    function is_four_wire;
        input [3:0] f;
        begin
            is_four_wire = (f == `RMC_FN_RES4) || (f == `RMC_FN_TEMP_RTD4) ||
                           (f == `RMC_FN_RATIO) || (f == `RMC_FN_CHAVG);
        end
    endfunction

    function is_current;
        input [3:0] f;
        begin
            is_current = (f == `RMC_FN_DCI) || (f == `RMC_FN_ACI);
        end
    endfunction

    // Whether a channel may be closed under the present function.
    function chan_offered;
        input [3:0] f;
        input [4:0] c;
        begin
            if (is_current(f))
                chan_offered = (c == 5'h15) || (c == 5'h16);
            else if (is_four_wire(f))
                chan_offered = (c >= 5'h01) && (c <= 5'h0A);
            else
                chan_offered = (c >= 5'h01) && (c <= 5'h14);
        end
    endfunction

    wire four_w  = is_four_wire(function_sel_in);
    wire current = is_current(function_sel_in);

    // Next relay pattern: measurement channels first, then function-driven relays.
    always @* begin
        nxt_relay = relay_out;
        if (close_req_in && chan_offered(function_sel_in, chan_in)) begin
            nxt_relay[22:1] = 22'h000000;
            nxt_relay[chan_in] = 1'b1;
            if (four_w)
                nxt_relay[chan_in + 5'h0A] = 1'b1;
        end else if (open_req_in && chan_in >= 5'h01 && chan_in <= 5'h16) begin
            nxt_relay[chan_in] = 1'b0;
            if (four_w && chan_in <= 5'h0A)
                nxt_relay[chan_in + 5'h0A] = 1'b0;
        end
        if (current)
            nxt_relay[22:1] = nxt_relay[22:1] & 22'h300000;
        // Current channels bypass the backplane relays, so both stay open.
        nxt_relay[`RMC_CH_POLE_SEL] = four_w;
        if (multi_mode_in && !current) begin
            nxt_relay[`RMC_CH_BP_SENSE] = bp_sense_set_in;
            nxt_relay[`RMC_CH_BP_INPUT] = bp_input_set_in;
        end else begin
            nxt_relay[`RMC_CH_BP_SENSE] = four_w && !current;
            nxt_relay[`RMC_CH_BP_INPUT] = !current;
        end
    end

    // Relay state; a count rises only on an open-to-closed edge of that relay.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            relay_out <= {NCH{1'b0}};
            for (i = 1; i <= NCH; i = i + 1)
                count_mem[i] <= {CW{1'b0}};
        end else if (ce_in) begin
            relay_out <= nxt_relay;
            for (i = 1; i <= NCH; i = i + 1)
                if (nxt_relay[i] && !relay_out[i])
                    count_mem[i] <= count_mem[i] + 1'b1;
        end
    end

    // Interval register: out-of-range writes are refused and flagged.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            interval_out     <= `RMC_INT_DEFAULT_MIN;
            interval_err_out <= 1'b0;
        end else if (ce_in) begin
            if (interval_wr_in) begin
                if (interval_in >= `RMC_INT_MIN_MIN && interval_in <= `RMC_INT_MAX_MIN) begin
                    interval_out     <= interval_in;
                    interval_err_out <= 1'b0;
                end else begin
                    interval_err_out <= 1'b1;
                end
            end
        end
    end

    assign save_done = save_busy_out && nv_ready_in && sptr_ff == NCH[4:0];

    rmc_save_timer u_timer (
        .clk_sys_in     (clk_sys_in),
        .nrst_in        (nrst_in),
        .ce_in          (ce_in),
        .minute_tick_in (minute_tick_in),
        .restart_in     (save_done),
        .interval_in    (interval_out),
        .expire_out     (timer_expire)
    );

    // Query walk: one count per cycle, first to last; a save is requested as the query arrives.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            query_busy_out  <= 1'b0;
            count_valid_out <= 1'b0;
            count_chan_out  <= 5'h00;
            count_data_out  <= {CW{1'b0}};
            qptr_ff         <= 5'h00;
            qlast_ff        <= 5'h00;
        end else if (ce_in) begin
            count_valid_out <= 1'b0;
            if (!query_busy_out && count_query_in && query_first_in >= 5'h01 &&
                query_last_in <= NCH[4:0] && query_first_in <= query_last_in) begin
                query_busy_out <= 1'b1;
                qptr_ff        <= query_first_in;
                qlast_ff       <= query_last_in;
            end else if (query_busy_out) begin
                count_valid_out <= 1'b1;
                count_chan_out  <= qptr_ff;
                count_data_out  <= count_mem[qptr_ff];
                qptr_ff         <= qptr_ff + 5'h01;
                if (qptr_ff == qlast_ff)
                    query_busy_out <= 1'b0;
            end
        end
    end

    // Save engine: copies all counts when the timer expires or a query arrives.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            save_pend_ff  <= 1'b0;
            save_busy_out <= 1'b0;
            sptr_ff       <= 5'h01;
            nv_wr_out     <= 1'b0;
            nv_addr_out   <= 5'h00;
            nv_data_out   <= {CW{1'b0}};
        end else if (ce_in) begin
            if (timer_expire || (count_query_in && !query_busy_out))
                save_pend_ff <= 1'b1;
            // Clearing only as a save starts keeps a trigger that lands mid-save.
            else if (!save_busy_out && save_pend_ff)
                save_pend_ff <= 1'b0;
            if (!save_busy_out && save_pend_ff) begin
                save_busy_out <= 1'b1;
                sptr_ff       <= 5'h01;
                nv_wr_out     <= 1'b1;
                nv_addr_out   <= 5'h01;
                nv_data_out   <= count_mem[1];
            end else if (save_busy_out && nv_ready_in) begin
                if (sptr_ff == NCH[4:0]) begin
                    save_busy_out <= 1'b0;
                    nv_wr_out     <= 1'b0;
                end else begin
                    sptr_ff     <= sptr_ff + 5'h01;
                    nv_addr_out <= sptr_ff + 5'h01;
                    nv_data_out <= count_mem[sptr_ff + 5'h01];
                end
            end
        end
    end
endmodule

// *** rmc_save_timer.v ***
`timescale 1ns/1ps
`include "rmc_consts.vh"
// Minute-based save interval timer; restarts on every save.
module rmc_save_timer (
    input  wire        clk_sys_in,
    input  wire        nrst_in,
    input  wire        ce_in,
    input  wire        minute_tick_in,
    input  wire        restart_in,
    input  wire [10:0] interval_in,
    output reg         expire_out
);
    reg [10:0] count_ff;
    reg [10:0] limit_ff;

    // The interval is latched at restart so a new setting waits for the next restart.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_ff   <= 11'h000;
            limit_ff   <= `RMC_INT_DEFAULT_MIN;
            expire_out <= 1'b0;
        end else if (ce_in) begin
            expire_out <= 1'b0;
            if (restart_in) begin
                count_ff <= 11'h000;
                limit_ff <= interval_in;
            end else if (minute_tick_in && !expire_out) begin
                if (count_ff + 11'h001 >= limit_ff) begin
                    expire_out <= 1'b1;
                    count_ff   <= limit_ff;
                end else begin
                    count_ff <= count_ff + 11'h001;
                end
            end
        end
    end
endmodule

// *** test_rmc_relay_ctrl.sv ***
`timescale 1ns/1ps
`include "rmc_consts.vh"
// Host-side stimulus and checks for the relay controller.
module test_rmc_relay_ctrl;
    logic        clk, nrst, close, open, iv_wr, tick, qry, slow, rdy, iv_err, cv, qb, nvw, sb;
    logic        ce, mm, bps, bpi;
    logic [2:0]  e;
    logic [3:0]  fn;
    logic [4:0]  ch, qf, ql, cc, nva;
    logic [10:0] iv, iv_o;
    logic [25:1] rel;
    logic [31:0] cd, nvd, cnt [1:25];
    int          err_count, cmp_count, n;
    rmc_relay_ctrl rmc_relay_ctrl_i (.clk_sys_in(clk), .nrst_in(nrst), .ce_in(ce),
        .function_sel_in(fn), .close_req_in(close), .open_req_in(open), .chan_in(ch),
        .multi_mode_in(mm), .bp_sense_set_in(bps), .bp_input_set_in(bpi),
        .interval_wr_in(iv_wr), .interval_in(iv), .minute_tick_in(tick),
        .count_query_in(qry), .query_first_in(qf), .query_last_in(ql), .nv_ready_in(rdy),
        .relay_out(rel), .interval_out(iv_o), .interval_err_out(iv_err),
        .count_valid_out(cv), .count_chan_out(cc), .count_data_out(cd), .query_busy_out(qb),
        .nv_wr_out(nvw), .nv_addr_out(nva), .nv_data_out(nvd), .save_busy_out(sb));
    rmc_nv_model rmc_nv_model_i (.clk_sys_in(clk), .nrst_in(nrst), .slow_in(slow),
        .nv_wr_in(nvw), .nv_addr_in(nva), .nv_data_in(nvd), .nv_ready_out(rdy));
    // Every comparison is tallied here; an unknown matches only the same unknown.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle relay request; the map has settled by the following falling edge.
    task automatic sw(input logic c, input logic [4:0] k, input logic [25:1] x);
        @(negedge clk);
        {close, open, ch} = {c, !c, k};
        @(negedge clk);
        {close, open} = 2'h0;
        chk(rel, x);
    endtask
    task automatic wr_iv(input logic [10:0] v, input logic x, input logic [10:0] r);
        @(negedge clk);
        {iv_wr, iv} = {1'b1, v};
        @(negedge clk);
        iv_wr = 1'b0;
        chk(iv_err, x);
        chk(iv_o, r);
    endtask
    // Bounded wait on the save flag; a save on a slow store takes about fifty cycles.
    task automatic wait_sb(input logic v);
        for (n = 0; n < 200 && sb !== v; n++) @(negedge clk);
    endtask
    task automatic ticks(input int k);
        repeat (k) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        close_out;
    end
    initial begin
        {nrst, close, open, iv_wr, tick, qry, slow} = 7'h00;
        {fn, ch, iv, qf, ql} = 30'h0;
        {ce, mm, bps, bpi} = 4'h8;
        for (int c = 1; c <= 25; c++) cnt[c] = 32'h0;
        repeat (10) @(negedge clk);
        chk(iv_o, `RMC_INT_DEFAULT_MIN);
        nrst = 1'b1;
        // Each function code sets the pole-select and backplane relays.
        for (int f = 0; f < 13; f++) begin
            @(negedge clk);
            fn = f[3:0];
            @(negedge clk);
            e = (fn == `RMC_FN_RES4 || fn > `RMC_FN_TEMP2) ? 3'h7 : 3'h4;
            chk(rel[25:23], fn[3:1] == 3'h1 ? 3'h0 : e);
        end
        fn = `RMC_FN_DCV;
        sw(1'b1, 5'h03, 25'h1000004);
        sw(1'b1, 5'h03, 25'h1000004);
        sw(1'b1, 5'h05, 25'h1000010);
        sw(1'b1, 5'h03, 25'h1000004);
        sw(1'b1, 5'h15, 25'h1000004);
        sw(1'b0, 5'h03, 25'h1000000);
        // Frozen by the clock enable, a close must leave relays and counts alone.
        ce = 1'b0;
        sw(1'b1, 5'h07, 25'h1000000);
        ce = 1'b1;
        // Multiple-channel mode hands the two backplane relays to the host.
        {mm, bps, bpi} = 3'h6;
        @(negedge clk);
        chk(rel, 25'h0800000);
        {mm, bps, bpi} = 3'h0;
        fn = `RMC_FN_RES4;
        sw(1'b1, 5'h02, 25'h1C00802);
        sw(1'b1, 5'h0C, 25'h1C00802);
        sw(1'b1, 5'h0A, 25'h1C80200);
        fn = `RMC_FN_DCI;
        sw(1'b1, 5'h15, 25'h0100000);
        sw(1'b1, 5'h16, 25'h0200000);
        {cnt[2], cnt[3], cnt[5], cnt[10]} = {32'h1, 32'h2, 32'h1, 32'h1};
        {cnt[12], cnt[20], cnt[21], cnt[22]} = {32'h1, 32'h1, 32'h1, 32'h1};
        wr_iv(11'h009, 1'b1, `RMC_INT_DEFAULT_MIN);
        wr_iv(11'h5A1, 1'b1, `RMC_INT_DEFAULT_MIN);
        wr_iv(11'h5A0, 1'b0, 11'h5A0);
        wr_iv(11'h00A, 1'b0, 11'h00A);
        // End-of-program query of every measurement channel, against a stalling store.
        slow = 1'b1;
        @(negedge clk);
        {qry, qf, ql} = {1'b1, 5'h01, 5'h16};
        @(negedge clk);
        qry = 1'b0;
        chk(qb, 1'b1);
        for (int c = 1; c <= 22; c++) begin
            for (n = 0; n < 9 && cv !== 1'b1; n++) @(negedge clk);
            chk(cc, c);
            chk(cd, cnt[c]);
            @(negedge clk);
        end
        chk(qb, 1'b0);
        chk(cv, 1'b0);
        wait_sb(1'b0);
        for (int c = 1; c <= 22; c++) chk(rmc_nv_model_i.mem[c], cnt[c]);
        // The save restarted the timer with the new ten-minute interval.
        ticks(9);
        repeat (4) @(negedge clk);
        chk(sb, 1'b0);
        ticks(1);
        wait_sb(1'b1);
        chk(sb, 1'b1);
        wait_sb(1'b0);
        close_out;
    end
endmodule
